// [hw/bcrf_consts.vh]
// Constants for the banked CPU register file
`ifndef BCRF_CONSTS_VH
`define BCRF_CONSTS_VH

// Access size codes on the pipeline ports
`define BCRF_SZ_BYTE     2'h0
`define BCRF_SZ_WORD     2'h1
`define BCRF_SZ_DWORD    2'h2

// Location limits of the register file
`define BCRF_LOC_BANK_LAST   6'h07
`define BCRF_LOC_BYTE_LAST   6'h0f
`define BCRF_LOC_WORD_LAST   6'h1e
`define BCRF_LOC_DWORD_LOW   6'h1c
`define BCRF_LOC_RSV_FIRST   6'h20
`define BCRF_LOC_RSV_LAST    6'h37

// Dedicated locations
`define BCRF_LOC_MULDIV      6'h0a
`define BCRF_LOC_ACC         6'h0b
`define BCRF_LOC_XDP         6'h38
`define BCRF_LOC_REGION      6'h39
`define BCRF_LOC_DPH         6'h3a
`define BCRF_LOC_DPL         6'h3b
`define BCRF_LOC_XSP         6'h3c
`define BCRF_LOC_SPH         6'h3e
`define BCRF_LOC_SPL         6'h3f

// Special-function alias addresses
`define BCRF_SFR_SPL         8'h81
`define BCRF_SFR_DPL         8'h82
`define BCRF_SFR_DPH         8'h83
`define BCRF_SFR_REGION      8'h84
`define BCRF_SFR_SPH         8'hbe
`define BCRF_SFR_ACC         8'he0
`define BCRF_SFR_MULDIV      8'hf0

// Reset values of the unbanked bytes
`define BCRF_RST_DEFAULT     8'h00
`define BCRF_RST_REGION      8'h01
`define BCRF_RST_SPL         8'h07

`endif

// [hw/bcrf_byte_reg.v]
// One unbanked register-file byte with its own reset value
`timescale 1ns/1ps
module bcrf_byte_reg #(
    parameter [7:0] RESET_VAL = 8'h00
) (
    input  wire       clock,
    input  wire       rst,
    input  wire       wr_en,
    input  wire [7:0] wr_data,
    output wire [7:0] q
);
    reg [7:0] byte_q;    // Stored byte

    // Load on write strobe, constant on reset
    always @(posedge clock) begin
        if (rst) begin
            byte_q <= RESET_VAL;
        end else if (wr_en) begin
            byte_q <= wr_data;
        end
    end

    assign q = byte_q;
endmodule // bcrf_byte_reg

// [hw/bcrf_bank_mem.v]
// Bank storage: 32 bytes of data RAM holding the four register banks
`timescale 1ns/1ps
module bcrf_bank_mem (
    input  wire        clock,
    input  wire [1:0]  bank,
    input  wire [7:0]  core_be,
    input  wire [63:0] core_wdata,
    output reg  [63:0] core_rdata,
    input  wire        dm_en,
    input  wire        dm_we,
    input  wire [4:0]  dm_addr,
    input  wire [7:0]  dm_wdata,
    output reg  [7:0]  dm_rdata
);
    reg [7:0] mem [0:31];    // Four banks of eight bytes
    integer   j;             // Byte loop index
    integer   jr;            // Read loop index

    // Core port writes win over the data port on the same byte
    always @(posedge clock) begin
        if (dm_en && dm_we) begin
            mem[dm_addr] <= dm_wdata;
        end
        for (j = 0; j < 8; j = j + 1) begin
            if (core_be[j]) begin
                mem[{bank, j[2:0]}] <= core_wdata[j*8 +: 8];
            end
        end
    end

    // Registered reads, old contents on a same-cycle write
    always @(posedge clock) begin
        for (jr = 0; jr < 8; jr = jr + 1) begin
            core_rdata[jr*8 +: 8] <= mem[{bank, jr[2:0]}];
        end
        if (dm_en) begin
            dm_rdata <= mem[dm_addr];
        end
    end
endmodule // bcrf_bank_mem

// [hw/bcrf_regfile.v]
// Banked CPU register file with byte, word and dword views and SFR aliases
//
// Overview of operation
// [RULE_01] Forty byte locations: 0-31 and 56-63.
// [RULE_02] Locations 0-7 live in four RAM banks.
// [RULE_03] Two status bits pick the active bank.
// [RULE_04] All banks stay reachable as RAM 00-1F.
// [RULE_05] Locations 8-31, 56-63 are unbanked flops.
// [RULE_06] Locations 32-55 reserved, no storage.
// [RULE_07] Multi-byte register named by lowest location.
// [RULE_08] Byte 0-15, word to 31, dword-only 56-63.
// [RULE_09] Accumulator, operand, data and stack pointers fixed.
// [RULE_10] Accumulator and operand also at E0, F0.
// [RULE_11] Register-file access one state faster than SFR.
// [RULE_12] Data pointer low bytes aliased at 82-84.
// [RULE_13] Pointer bytes reached only as dwords.
// [RULE_14] Data pointer low/high form 16-bit pointer.
// [RULE_15] Location 57 gives region, resets to 01.
// [RULE_16] Stack bytes 63, 62 aliased at 81, BE.
// [RULE_17] Stack operations address through dword 60.
// [RULE_18] Status flags follow only the accumulator.
// [RULE_19] Reserved access changes nothing, reads undefined.
`timescale 1ns/1ps
`include "bcrf_consts.vh"
module bcrf_regfile (
    input  wire        clock,
    input  wire        rst,
    input  wire        bank_sel_hi,
    input  wire        bank_sel_lo,
    input  wire        rf_rd_en,
    input  wire [5:0]  rf_rd_loc,
    input  wire [1:0]  rf_rd_size,
    output reg         rf_rd_valid,
    output reg         rf_rd_err,
    output reg  [31:0] rf_rd_data,
    input  wire        rf_wr_en,
    input  wire [5:0]  rf_wr_loc,
    input  wire [1:0]  rf_wr_size,
    input  wire [31:0] rf_wr_data,
    output reg         rf_wr_err,
    input  wire        sfr_rd_en,
    input  wire        sfr_wr_en,
    input  wire [7:0]  sfr_addr,
    input  wire [7:0]  sfr_wr_data,
    output reg         sfr_rd_valid,
    output reg         sfr_rd_hit,
    output reg  [7:0]  sfr_rd_data,
    input  wire        dm_en,
    input  wire        dm_we,
    input  wire [4:0]  dm_addr,
    input  wire [7:0]  dm_wdata,
    output wire [7:0]  dm_rdata,
    output reg         dm_rd_valid,
    output wire [15:0] legacy_data_ptr16,
    output wire [7:0]  ext_region_select,
    output wire [31:0] extended_data_pointer,
    output wire [31:0] extended_stack_pointer,
    output wire [7:0]  main_operand_byte,
    output wire [7:0]  mul_div_operand,
    output reg         acc_parity
);
    wire [1:0]   bank_sel;       // Active bank code
    wire [511:0] loc_flat;       // All 64 location bytes, unbanked part only
    wire [63:0]  bank_row;       // Registered active-bank row
    reg  [63:0]  wbe;            // Per-location write strobes
    reg  [511:0] wbyte;          // Per-location write bytes
    reg          rd_ok;          // Read request legal
    reg          wr_ok;          // Write request legal
    reg          sfr_hit;        // SFR address is an alias
    reg  [5:0]   sfr_loc;        // Location behind the SFR alias
    reg  [31:0]  up4_d;          // Four bytes from the read location
    reg  [31:0]  rd_data_d;      // Assembled read answer
    reg  [6:0]   idx;            // Location index scratch
    reg  [6:0]   off;            // Write byte offset
    reg  [2:0]   wlen;           // Write length in bytes
    integer      i;              // Location loop index
    integer      pos;            // Byte lane within write data
    integer      iu;             // Gather loop index
    integer      ir;             // Merge loop index
    reg  [6:0]   idx_r;          // Merge location scratch

    // Read pipeline stage one
    reg          rd_v1_q;
    reg          rd_ok1_q;
    reg  [5:0]   rd_loc1_q;
    reg  [1:0]   rd_size1_q;
    reg  [31:0]  up4_q;
    // SFR read pipeline, one state longer than the register path
    reg          sfr_v1_q;
    reg          sfr_v2_q;
    reg          sfr_h1_q;
    reg          sfr_h2_q;
    reg  [7:0]   sfr_b1_q;
    reg  [7:0]   sfr_b2_q;

    // Legal size and location pairs
    function legal_acc;
        input [5:0] loc;
        input [1:0] sz;
        begin
            case (sz)
                `BCRF_SZ_BYTE:  legal_acc = (loc <= `BCRF_LOC_BYTE_LAST);
                `BCRF_SZ_WORD:  legal_acc = !loc[0] && (loc <= `BCRF_LOC_WORD_LAST);
                `BCRF_SZ_DWORD: legal_acc = (loc[1:0] == 2'h0) &&
                                            ((loc <= `BCRF_LOC_DWORD_LOW) ||
                                             (loc == `BCRF_LOC_XDP) || (loc == `BCRF_LOC_XSP));
                default:        legal_acc = 1'b0;
            endcase
        end
    endfunction

    // Bank code from the status word bits
    assign bank_sel = {bank_sel_hi, bank_sel_lo}; // [RULE_03]

    // Request legality and SFR alias decode
    always @* begin
        rd_ok   = legal_acc(rf_rd_loc, rf_rd_size); // [RULE_08]
        wr_ok   = legal_acc(rf_wr_loc, rf_wr_size); // [RULE_13]
        sfr_hit = 1'b1;
        sfr_loc = `BCRF_LOC_ACC;
        case (sfr_addr)
            `BCRF_SFR_ACC:    sfr_loc = `BCRF_LOC_ACC;    // [RULE_10]
            `BCRF_SFR_MULDIV: sfr_loc = `BCRF_LOC_MULDIV; // [RULE_10]
            `BCRF_SFR_DPL:    sfr_loc = `BCRF_LOC_DPL;    // [RULE_12]
            `BCRF_SFR_DPH:    sfr_loc = `BCRF_LOC_DPH;    // [RULE_12]
            `BCRF_SFR_REGION: sfr_loc = `BCRF_LOC_REGION; // [RULE_12]
            `BCRF_SFR_SPL:    sfr_loc = `BCRF_LOC_SPL;    // [RULE_16]
            `BCRF_SFR_SPH:    sfr_loc = `BCRF_LOC_SPH;    // [RULE_16]
            default:          sfr_hit = 1'b0;
        endcase
    end

    // Write strobes per location; register-file write beats SFR write
    // Illegal requests raise no strobe at all
    always @* begin
        wbe   = 64'h0;
        wbyte = 512'h0;
        off   = 7'h0;
        pos   = 0;
        case (rf_wr_size)
            `BCRF_SZ_BYTE: wlen = 3'h1;
            `BCRF_SZ_WORD: wlen = 3'h2;
            default:       wlen = 3'h4;
        endcase
        for (i = 0; i < 64; i = i + 1) begin
            off = i[6:0] - {1'b0, rf_wr_loc};
            if (rf_wr_en && wr_ok && (i >= rf_wr_loc) && (off < {4'h0, wlen})) begin // [RULE_19]
                pos = wlen - 1 - off;                                                  // [RULE_07]
                wbe[i] = 1'b1;
                wbyte[i*8 +: 8] = rf_wr_data[pos*8 +: 8];
            end else if (sfr_wr_en && sfr_hit && (i == sfr_loc)) begin
                wbe[i] = 1'b1;
                wbyte[i*8 +: 8] = sfr_wr_data;
            end
        end
    end

    // Banked locations 0-7 in the first 32 RAM bytes
    bcrf_bank_mem u_bank_mem ( // [RULE_02]
        .clock      (clock),
        .bank       (bank_sel),
        .core_be    (wbe[7:0]),
        .core_wdata (wbyte[63:0]),
        .core_rdata (bank_row),
        .dm_en      (dm_en),      // [RULE_04]
        .dm_we      (dm_we),
        .dm_addr    (dm_addr),
        .dm_wdata   (dm_wdata),
        .dm_rdata   (dm_rdata)
    );

    // Unbanked flops at 8-31 and 56-63; no storage for 32-55
    // Empty slots read as zero and take no writes
    genvar g;
    generate
        for (g = 0; g < 64; g = g + 1) begin : g_loc // [RULE_01]
            if ((g >= 8 && g < 32) || g >= 56) begin : g_reg // [RULE_05]
                bcrf_byte_reg #(
                    .RESET_VAL ((g == 57) ? `BCRF_RST_REGION :                  // [RULE_15]
                                (g == 63) ? `BCRF_RST_SPL : `BCRF_RST_DEFAULT)
                ) u_byte (
                    .clock   (clock),
                    .rst     (rst),
                    .wr_en   (wbe[g]),
                    .wr_data (wbyte[g*8 +: 8]),
                    .q       (loc_flat[g*8 +: 8])
                );
            end else begin : g_none // [RULE_06]
                assign loc_flat[g*8 +: 8] = 8'h00;
            end
        end
    endgenerate

    // Gather four unbanked bytes starting at the read location
    // Bytes past location 63 stay zero
    always @* begin
        up4_d = 32'h0;
        idx   = 7'h0;
        for (iu = 0; iu < 4; iu = iu + 1) begin
            idx = {1'b0, rf_rd_loc} + iu[6:0];
            if (idx < 7'h40) begin
                up4_d[(3-iu)*8 +: 8] = loc_flat[idx[5:0]*8 +: 8];
            end
        end
    end

    // Stage one of reads and side-port bookkeeping
    always @(posedge clock) begin
        if (rst) begin
            rd_v1_q     <= 1'b0;
            rd_ok1_q    <= 1'b0;
            rd_loc1_q   <= 6'h00;
            rd_size1_q  <= 2'h0;
            up4_q       <= 32'h0;
            rf_wr_err   <= 1'b0;
            dm_rd_valid <= 1'b0;
            acc_parity  <= 1'b0;
        end else begin
            rd_v1_q     <= rf_rd_en;
            rd_ok1_q    <= rd_ok;
            rd_loc1_q   <= rf_rd_loc;
            rd_size1_q  <= rf_rd_size;
            up4_q       <= up4_d;
            rf_wr_err   <= rf_wr_en && !wr_ok;             // [RULE_19]
            dm_rd_valid <= dm_en && !dm_we;
            acc_parity  <= ^loc_flat[`BCRF_LOC_ACC*8 +: 8]; // [RULE_18]
        end
    end

    // Merge banked row bytes and shape by size, lowest location most significant
    // Bank row was read with the bank code of the request edge
    always @* begin
        rd_data_d = up4_q;
        idx_r     = 7'h0;
        for (ir = 0; ir < 4; ir = ir + 1) begin
            idx_r = {1'b0, rd_loc1_q} + ir[6:0];
            if (idx_r <= {1'b0, `BCRF_LOC_BANK_LAST}) begin
                rd_data_d[(3-ir)*8 +: 8] = bank_row[idx_r[2:0]*8 +: 8];
            end
        end
        case (rd_size1_q)
            `BCRF_SZ_BYTE: rd_data_d = {24'h0, rd_data_d[31:24]}; // [RULE_07]
            `BCRF_SZ_WORD: rd_data_d = {16'h0, rd_data_d[31:16]};
            default:       rd_data_d = rd_data_d;
        endcase
        if (!rd_ok1_q) begin
            rd_data_d = 32'h0; // [RULE_19]
        end
    end

    // Register-file answer two cycles after the request
    always @(posedge clock) begin
        if (rst) begin
            rf_rd_valid <= 1'b0;
            rf_rd_err   <= 1'b0;
            rf_rd_data  <= 32'h0;
        end else begin
            rf_rd_valid <= rd_v1_q;
            rf_rd_err   <= rd_v1_q && !rd_ok1_q;
            rf_rd_data  <= rd_data_d;
        end
    end

    // SFR alias reads take one more state than register reads
    // Extra stage keeps alias answers one state behind
    always @(posedge clock) begin
        if (rst) begin
            sfr_v1_q     <= 1'b0;
            sfr_v2_q     <= 1'b0;
            sfr_h1_q     <= 1'b0;
            sfr_h2_q     <= 1'b0;
            sfr_b1_q     <= 8'h00;
            sfr_b2_q     <= 8'h00;
            sfr_rd_valid <= 1'b0;
            sfr_rd_hit   <= 1'b0;
            sfr_rd_data  <= 8'h00;
        end else begin
            sfr_v1_q     <= sfr_rd_en;
            sfr_h1_q     <= sfr_hit;
            sfr_b1_q     <= sfr_hit ? loc_flat[sfr_loc*8 +: 8] : 8'h00;
            sfr_v2_q     <= sfr_v1_q;  // [RULE_11]
            sfr_h2_q     <= sfr_h1_q;
            sfr_b2_q     <= sfr_b1_q;
            sfr_rd_valid <= sfr_v2_q;
            sfr_rd_hit   <= sfr_v2_q && sfr_h2_q;
            sfr_rd_data  <= sfr_b2_q;
        end
    end

    // Dedicated register views for the pipeline
    assign legacy_data_ptr16      = {loc_flat[`BCRF_LOC_DPH*8 +: 8],
                                     loc_flat[`BCRF_LOC_DPL*8 +: 8]};    // [RULE_14]
    assign ext_region_select      = loc_flat[`BCRF_LOC_REGION*8 +: 8];   // [RULE_15]
    assign extended_data_pointer  = {loc_flat[`BCRF_LOC_XDP*8 +: 8],
                                     loc_flat[`BCRF_LOC_REGION*8 +: 8],
                                     legacy_data_ptr16};                 // [RULE_09]
    assign extended_stack_pointer = {loc_flat[`BCRF_LOC_XSP*8 +: 8],
                                     loc_flat[(`BCRF_LOC_XSP+1)*8 +: 8],
                                     loc_flat[`BCRF_LOC_SPH*8 +: 8],
                                     loc_flat[`BCRF_LOC_SPL*8 +: 8]};    // [RULE_17]
    assign main_operand_byte      = loc_flat[`BCRF_LOC_ACC*8 +: 8];      // [RULE_09]
    assign mul_div_operand        = loc_flat[`BCRF_LOC_MULDIV*8 +: 8];

    // Bank bytes have no reset; load them before use
    // Size code 3 is refused like any illegal pair
endmodule // bcrf_regfile

// [verification/bcrf_regfile_chk.sv]
// Port-level assertions for the banked register file
`timescale 1ns/1ps
module bcrf_regfile_chk (
    input wire        clock,
    input wire        rst,
    input wire        rf_rd_en,
    input wire [5:0]  rf_rd_loc,
    input wire [1:0]  rf_rd_size,
    input wire        rf_rd_valid,
    input wire        rf_rd_err,
    input wire [31:0] rf_rd_data,
    input wire        rf_wr_en,
    input wire [5:0]  rf_wr_loc,
    input wire        rf_wr_err,
    input wire        sfr_rd_en,
    input wire [7:0]  sfr_addr,
    input wire        sfr_rd_valid,
    input wire        sfr_rd_hit,
    input wire        dm_en,
    input wire        dm_we,
    input wire        dm_rd_valid,
    input wire [15:0] legacy_data_ptr16,
    input wire [7:0]  ext_region_select,
    input wire [31:0] extended_data_pointer,
    input wire [7:0]  main_operand_byte,
    input wire        acc_parity
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Register answer two edges after the request
    sequence s_rd_ans; ##2 rf_rd_valid; endsequence
    // Refused answer: error with zero data
    sequence s_rd_bad; ##2 (rf_rd_valid && rf_rd_err && rf_rd_data == 32'h0); endsequence
    property p_rd_lat; rf_rd_en |-> s_rd_ans; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("register read answer missing");
    property p_rd_rsv; rf_rd_en && rf_rd_loc >= 6'h20 && rf_rd_loc <= 6'h37 |-> s_rd_bad; endproperty
    a_rd_rsv: assert property (p_rd_rsv) else $error("reserved read not refused");
    property p_rd_ptr; rf_rd_en && rf_rd_loc >= 6'h38 && rf_rd_size != 2'h2 |-> s_rd_bad; endproperty
    a_rd_ptr: assert property (p_rd_ptr) else $error("pointer byte read not refused");
    property p_wr_rsv; rf_wr_en && rf_wr_loc >= 6'h20 && rf_wr_loc <= 6'h37 |=> rf_wr_err; endproperty
    a_wr_rsv: assert property (p_wr_rsv) else $error("reserved write not refused");
    property p_sfr_lat; sfr_rd_en |-> ##3 sfr_rd_valid; endproperty
    a_sfr_lat: assert property (p_sfr_lat) else $error("alias read timing wrong");
    property p_sfr_src; sfr_rd_valid |-> $past(sfr_rd_en, 3); endproperty
    a_sfr_src: assert property (p_sfr_src) else $error("alias answer at wrong time");
    property p_sfr_acc; sfr_rd_en && (sfr_addr == 8'he0 || sfr_addr == 8'hf0) |-> ##3 sfr_rd_hit; endproperty
    a_sfr_acc: assert property (p_sfr_acc) else $error("operand alias missed");
    property p_dm_lat; dm_en && !dm_we |=> dm_rd_valid; endproperty
    a_dm_lat: assert property (p_dm_lat) else $error("bank ram read answer missing");
    property p_ptr16; legacy_data_ptr16 == extended_data_pointer[15:0]; endproperty
    a_ptr16: assert property (p_ptr16) else $error("legacy pointer mismatch");
    property p_region; ext_region_select == extended_data_pointer[23:16]; endproperty
    a_region: assert property (p_region) else $error("region byte mismatch");
    property p_parity; acc_parity == ^$past(main_operand_byte); endproperty
    a_parity: assert property (p_parity) else $error("parity does not follow operand");
endmodule // bcrf_regfile_chk
bind bcrf_regfile bcrf_regfile_chk u_chk (.clock, .rst, .rf_rd_en, .rf_rd_loc, .rf_rd_size, .rf_rd_valid,
    .rf_rd_err, .rf_rd_data, .rf_wr_en, .rf_wr_loc, .rf_wr_err, .sfr_rd_en, .sfr_addr, .sfr_rd_valid,
    .sfr_rd_hit, .dm_en, .dm_we, .dm_rd_valid, .legacy_data_ptr16, .ext_region_select,
    .extended_data_pointer, .main_operand_byte, .acc_parity);

// [verification/bcrf_dm_model.sv]
// Data RAM side model issuing byte accesses to the bank area
`timescale 1ns/1ps
module bcrf_dm_model (
    input  wire       clock,
    output logic      dm_en,
    output logic      dm_we,
    output logic [4:0] dm_addr,
    output logic [7:0] dm_wdata,
    input  wire [7:0] dm_rdata,
    input  wire       dm_rd_valid
);
    // Idle port at time zero
    initial begin
        {dm_en, dm_we} = 2'h0;
        dm_addr = 5'h00;
        dm_wdata = 8'h00;
    end
    // One byte access, held up to its taking edge
    task automatic access(input logic we, input logic [4:0] a, input logic [7:0] wd, output logic [7:0] rd);
        @(posedge clock);
        dm_en <= 1'b1;
        dm_we <= we;
        dm_addr <= a;
        dm_wdata <= wd;
        @(posedge clock);
        dm_en <= 1'b0;
        dm_we <= 1'b0;
        dm_addr <= ~a; // Released lines show no stale value
        dm_wdata <= ~wd;
        #1;
        rd = dm_rdata;
    endtask
endmodule // bcrf_dm_model

// [verification/tb_banked_cpu_register_file.sv]
// Self-checking bench for the banked register file
`timescale 1ns/1ps
module tb_banked_cpu_register_file;
    logic        clock, rst, bank_sel_hi, bank_sel_lo, rf_rd_en, rf_wr_en, sfr_rd_en, sfr_wr_en;
    logic [5:0]  rf_rd_loc, rf_wr_loc;
    logic [1:0]  rf_rd_size, rf_wr_size, bank;
    logic [31:0] rf_wr_data;
    logic [7:0]  sfr_addr, sfr_wr_data;
    wire         dm_en, dm_we, rf_rd_valid, rf_rd_err, rf_wr_err, sfr_rd_valid, sfr_rd_hit, dm_rd_valid, acc_parity;
    wire  [4:0]  dm_addr;
    wire  [7:0]  dm_wdata, dm_rdata, sfr_rd_data, ext_region_select, main_operand_byte, mul_div_operand;
    wire  [31:0] rf_rd_data, extended_data_pointer, extended_stack_pointer;
    wire  [15:0] legacy_data_ptr16;
    logic [7:0]  sh [0:63];       // Expected unbanked bytes
    logic [7:0]  bk [0:31];       // Expected bank RAM
    int          mismatches = 0;
    int          num_checks = 0;
    localparam logic [5:0] CL [8] = '{6'h20, 6'h37, 6'h38, 6'h39, 6'h1f, 6'h1e, 6'h10, 6'h3c};
    localparam logic [1:0] CS [8] = '{2'h2, 2'h0, 2'h0, 2'h2, 2'h1, 2'h1, 2'h0, 2'h2};
    localparam logic [7:0] SA [8] = '{8'he0, 8'hf0, 8'h81, 8'h82, 8'h83, 8'h84, 8'hbe, 8'h85};
    localparam logic [5:0] SL [8] = '{6'h0b, 6'h0a, 6'h3f, 6'h3b, 6'h3a, 6'h39, 6'h3e, 6'h00};

    bcrf_regfile dut (.clock, .rst, .bank_sel_hi, .bank_sel_lo, .rf_rd_en, .rf_rd_loc, .rf_rd_size, .rf_rd_valid,
        .rf_rd_err, .rf_rd_data, .rf_wr_en, .rf_wr_loc, .rf_wr_size, .rf_wr_data, .rf_wr_err, .sfr_rd_en,
        .sfr_wr_en, .sfr_addr, .sfr_wr_data, .sfr_rd_valid, .sfr_rd_hit, .sfr_rd_data, .dm_en, .dm_we, .dm_addr,
        .dm_wdata, .dm_rdata, .dm_rd_valid, .legacy_data_ptr16, .ext_region_select, .extended_data_pointer,
        .extended_stack_pointer, .main_operand_byte, .mul_div_operand, .acc_parity);
    bcrf_dm_model pm (.clock, .dm_en, .dm_we, .dm_addr, .dm_wdata, .dm_rdata, .dm_rd_valid);

    // Legal size and location pairs
    function automatic logic legal(input logic [5:0] l, input logic [1:0] s);
        case (s)
            2'h0: return l <= 6'h0f;
            2'h1: return !l[0] && l <= 6'h1e;
            2'h2: return (l[1:0] == 2'h0 && l <= 6'h1c) || l == 6'h38 || l == 6'h3c;
            default: return 1'b0;
        endcase
    endfunction
    // Expected value, lowest location most significant
    function automatic logic [31:0] expv(input logic [5:0] l, input logic [1:0] s);
        logic [31:0] v;
        v = 32'h0;
        for (int i = 0; i < (1 << s); i++) v = {v[23:0], l + i < 8 ? bk[{bank, 3'h0} + l + i] : sh[l + i]};
        return v;
    endfunction
    // Shadow update for a legal write
    task automatic sh_wr(input logic [5:0] l, input logic [1:0] s, input logic [31:0] d);
        int n;
        n = 1 << s;
        for (int i = 0; i < n; i++) begin
            if (l + i < 8) bk[{bank, 3'h0} + l + i] = d[8 * (n - 1 - i) +: 8];
            else sh[l + i] = d[8 * (n - 1 - i) +: 8];
        end
    endtask
    // Reset values of unbanked bytes
    task automatic sh_reset();
        for (int i = 0; i < 64; i++) sh[i] = 8'h00;
        sh[57] = 8'h01;
        sh[63] = 8'h07;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic set_bank(input logic [1:0] b);
        @(posedge clock);
        {bank_sel_hi, bank_sel_lo} <= b;
        bank = b;
    endtask
    // Register write or read; waits a bounded time for the answer
    task automatic rf_op(input logic we, input logic [5:0] l, input logic [1:0] s, input logic [31:0] d,
                         output logic [31:0] r, output logic e);
        @(posedge clock);
        rf_wr_en <= we;
        rf_rd_en <= !we;
        {rf_wr_loc, rf_rd_loc} <= {l, l};
        {rf_wr_size, rf_rd_size} <= {s, s};
        rf_wr_data <= d;
        @(posedge clock);
        {rf_wr_en, rf_rd_en} <= 2'h0;
        rf_wr_data <= ~d;
        #1;
        e = rf_wr_err;
        for (int i = 0; i < 4 && !we && rf_rd_valid !== 1'b1; i++) begin
            @(posedge clock);
            #1;
        end
        if (!we) chk("rd_valid", 1, rf_rd_valid);
        r = rf_rd_data;
        if (!we) e = rf_rd_err;
    endtask
    // Alias write or read
    task automatic sfr_op(input logic we, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r,
                          output logic h);
        @(posedge clock);
        sfr_wr_en <= we;
        sfr_rd_en <= !we;
        sfr_addr <= a;
        sfr_wr_data <= d;
        @(posedge clock);
        {sfr_wr_en, sfr_rd_en} <= 2'h0;
        sfr_wr_data <= ~d;
        #1;
        for (int i = 0; i < 5 && !we && sfr_rd_valid !== 1'b1; i++) begin
            @(posedge clock);
            #1;
        end
        if (!we) chk("sfr_valid", 1, sfr_rd_valid);
        r = sfr_rd_data;
        h = sfr_rd_hit;
    endtask
    task automatic summarize();
        if (mismatches == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Free-running clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // Hang guard
    initial begin
        #100000;
        mismatches++;
        summarize();
    end
    // Main sequence
    initial begin
        logic [31:0] d, r;
        logic [7:0]  b8, h8;
        logic        e, h;
        logic [5:0]  l;
        logic [1:0]  s;
        rst = 1'b1;
        bank = 2'h0;
        {rf_rd_en, rf_wr_en, sfr_rd_en, sfr_wr_en, bank_sel_hi, bank_sel_lo} = 6'h00;
        {rf_rd_loc, rf_wr_loc, rf_rd_size, rf_wr_size, rf_wr_data, sfr_addr, sfr_wr_data} = '0;
        d = $urandom(32'h44f0465a);
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        sh_reset();
        rf_op(1'b0, 6'h38, 2'h2, 32'h0, r, e);
        chk("dword56", 32'h00010000, r);
        rf_op(1'b0, 6'h3c, 2'h2, 32'h0, r, e);
        chk("dword60", 32'h00000007, r);
        // Fill every bank, then read all of them through the RAM port
        for (int k = 0; k < 8; k++) begin
            set_bank(2'(k >> 1));
            d = $urandom;
            rf_op(1'b1, {3'h0, k[0], 2'h0}, 2'h2, d, r, e);
            sh_wr({3'h0, k[0], 2'h0}, 2'h2, d);
        end
        for (int k = 0; k < 32; k++) begin
            pm.access(1'b0, k[4:0], 8'h00, b8);
            chk("dm_read", bk[k], b8);
        end
        b8 = $urandom;
        l = $urandom;
        pm.access(1'b1, l[4:0], b8, h8);
        bk[l[4:0]] = b8;
        set_bank(l[4:3]);
        rf_op(1'b0, {3'h0, l[2:0]}, 2'h0, 32'h0, r, e);
        chk("bank_byte", b8, r);
        // Corner and random writes and reads
        for (int k = 0; k < 80; k++) begin
            set_bank(2'($urandom));
            l = k < 8 ? CL[k] : 6'($urandom);
            s = k < 8 ? CS[k] : 2'($urandom);
            d = $urandom;
            rf_op(1'b1, l, s, d, r, e);
            chk("wr_err", !legal(l, s), e);
            if (legal(l, s)) sh_wr(l, s, d);
            if (k[0]) s = 2'($urandom);
            rf_op(1'b0, l, s, 32'h0, r, e);
            chk("rd_err", !legal(l, s), e);
            chk("rd_data", legal(l, s) ? expv(l, s) : 32'h0, r);
            chk("acc_port", sh[11], main_operand_byte);
            chk("muldiv_port", sh[10], mul_div_operand);
            chk("parity", ^sh[11], acc_parity);
        end
        // Every alias plus one unmapped address
        for (int k = 0; k < 8; k++) begin
            b8 = $urandom;
            sfr_op(1'b1, SA[k], b8, h8, h);
            if (k < 7) sh[SL[k]] = b8;
            sfr_op(1'b0, SA[k], 8'h00, h8, h);
            chk("sfr_hit", k < 7, h);
            chk("sfr_data", k < 7 ? b8 : 8'h00, h8);
            l = SL[k] >= 6'h38 ? SL[k] & 6'h3c : SL[k];
            s = l >= 6'h38 ? 2'h2 : 2'h0;
            rf_op(1'b0, l, s, 32'h0, r, e);
            chk("alias_rf", expv(l, s), r);
        end
        chk("ptr16", {sh[58], sh[59]}, legacy_data_ptr16);
        chk("stack_ptr", {sh[60], sh[61], sh[62], sh[63]}, extended_stack_pointer);
        chk("data_ptr", {sh[56], sh[57], sh[58], sh[59]}, extended_data_pointer);
        // Second reset in mid-run
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        sh_reset();
        rf_op(1'b0, 6'h3c, 2'h2, 32'h0, r, e);
        chk("dword60_again", expv(6'h3c, 2'h2), r);
        chk("region_port", 8'h01, ext_region_select);
        summarize();
    end
endmodule // tb_banked_cpu_register_file
